/* File: core/mgd_config_regs.sv */
// Purpose: Configuration register bank of the gate-drive device, reached over
//          the device's serial host port as decoded register accesses.
// Assumes: The host port delivers one-cycle write and read strobes with an
//          8-bit register offset and 32-bit data on i_sys_clk.
// Notes:   Read data lands one cycle after the strobe with o_rd_valid.
`include "mgd_params.svh"
module mgd_config_regs
  import mgd_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_nrst,
  // Host register port
  input  wire logic        i_wr_en,
  input  wire logic        i_rd_en,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wr_data,
  output logic      [31:0] o_rd_data,
  output logic             o_rd_valid,
  output logic             o_addr_err,
  // Speed input by frequency
  input  wire logic        i_freq_sample,
  input  wire logic [14:0] i_freq_hz,
  output logic      [6:0]  o_duty_pct,
  output logic             o_duty_valid,
  // Device controls
  output logic             o_aux_feature_enable,
  output logic             o_spread_spectrum_on,
  output logic             o_sleep_select,
  output logic      [16:0] o_pwm_band_min_hz,
  output logic      [16:0] o_pwm_band_max_hz,
  output logic             o_use_external_clock,
  output logic             o_clk_src_invalid,
  output logic      [10:0] o_ext_clock_khz,
  output logic      [10:0] o_deadtime_ns,
  output logic      [7:0]  o_deadtime_cycles,
  // Gate-drive controls
  output logic             o_csa_bidirectional,
  output logic             o_bootstrap_fault_enable,
  output logic             o_overtemp_auto_restart,
  output logic             o_shunt_oc_enable,
  output logic             o_drain_source_oc_enable,
  output logic      [11:0] o_vds_trip_mv,
  output logic      [5:0]  o_sense_amp_gain,
  output logic      [31:0] o_gate_drive_setup_2
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] device_setup;
    logic [31:0] gate_drive_setup_1;
    logic [31:0] gate_drive_setup_2;
    logic [31:0] rd_data;
    logic        rd_valid;
    logic        addr_err;
    logic        aux_en;
    logic        ssm_on;
    logic        sleep_sel;
    logic [16:0] band_min;
    logic [16:0] band_max;
    logic        use_ext;
    logic        src_bad;
    logic [10:0] ext_khz;
    logic        csa_bidir;
    logic        bst_en;
    logic        ot_auto;
    logic        sns_en;
    logic        vds_en;
    logic [11:0] trip_mv;
    logic [5:0]  gain;
    logic [6:0]  duty;
    logic        duty_valid;
    logic        start;
  } mgd_regs_type;

  mgd_regs_type s_q;
  mgd_regs_type s_d;

  logic [1:0]  clk_src;
  logic [2:0]  ext_rate;
  logic [3:0]  trip_code;
  logic        div_done;
  logic        div_busy;
  logic [6:0]  div_duty;
  logic [3:0]  dt_code;

  // Drain-source trip thresholds in millivolts, code 0 first
  localparam logic [11:0] VDS_TRIP_MV [16] = '{
    12'h03C, 12'h078, 12'h0B4, 12'h0F0, 12'h12C, 12'h168, 12'h1A4, 12'h1E0,
    12'h258, 12'h320, 12'h3E8, 12'h4B0, 12'h578, 12'h640, 12'h708, 12'h7D0
  };

  assign clk_src   = s_q.device_setup[`MGD_DS_CLK_SRC_HI:`MGD_DS_CLK_SRC_LO];
  assign ext_rate  = s_q.device_setup[`MGD_DS_EXT_RATE_HI:`MGD_DS_EXT_RATE_LO];
  assign trip_code = s_q.gate_drive_setup_1[`MGD_GD_TRIP_HI:`MGD_GD_TRIP_LO];
  assign dt_code   = s_q.device_setup[`MGD_DS_DEADTIME_HI:`MGD_DS_DEADTIME_LO];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d          = s_q;
    s_d.rd_valid = 1'b0;
    s_d.addr_err = 1'b0;
    s_d.start    = 1'b0;

    // Register writes keep every bit, reserved fields included
    if (i_wr_en) begin
      if (i_addr == `MGD_OFS_DEVICE_SETUP) begin
        s_d.device_setup = i_wr_data;
      end else if (i_addr == `MGD_OFS_GATE_DRIVE_SETUP_1) begin
        s_d.gate_drive_setup_1 = i_wr_data;
      end else if (i_addr == `MGD_OFS_GATE_DRIVE_SETUP_2) begin
        s_d.gate_drive_setup_2 = i_wr_data;
      end else begin
        // Unlisted offsets are dropped; the host is expected not to use them
        s_d.addr_err = 1'b1;
      end
    end

    if (i_rd_en) begin
      s_d.rd_valid = 1'b1;
      if (i_addr == `MGD_OFS_DEVICE_SETUP) begin
        s_d.rd_data = s_q.device_setup;
      end else if (i_addr == `MGD_OFS_GATE_DRIVE_SETUP_1) begin
        s_d.rd_data = s_q.gate_drive_setup_1;
      end else if (i_addr == `MGD_OFS_GATE_DRIVE_SETUP_2) begin
        s_d.rd_data = s_q.gate_drive_setup_2;
      end else begin
        s_d.rd_data  = 32'h0000_0000;
        s_d.addr_err = 1'b1;
      end
    end

    // Decoded device controls
    s_d.aux_en    = s_q.device_setup[`MGD_DS_AUX_EN];
    s_d.ssm_on    = ~s_q.device_setup[`MGD_DS_SSM_DIS];
    s_d.sleep_sel = (s_q.device_setup[`MGD_DS_LOW_POWER] == MGD_LP_SLEEP);
    if (s_q.device_setup[`MGD_DS_PWM_BAND]) begin
      s_d.band_min = 17'(`MGD_BAND_LOW_MIN_HZ);
      s_d.band_max = 17'(`MGD_BAND_LOW_MAX_HZ);
    end else begin
      s_d.band_min = 17'(`MGD_BAND_HIGH_MIN_HZ);
      s_d.band_max = 17'(`MGD_BAND_HIGH_MAX_HZ);
    end
    // External clock only when selected by source and enabled
    s_d.use_ext = (clk_src == `MGD_CLK_SRC_EXTERNAL) && s_q.device_setup[`MGD_DS_EXTERNAL_CLOCK_ENABLE];
    // Invalid source codes fall back to the internal oscillator
    s_d.src_bad = (clk_src != `MGD_CLK_SRC_INTERNAL) && (clk_src != `MGD_CLK_SRC_EXTERNAL);
    s_d.ext_khz = 11'(`MGD_EXT_RATE_BASE_KHZ) << ext_rate;

    // Decoded gate-drive controls
    s_d.csa_bidir = s_q.gate_drive_setup_1[`MGD_GD_CSA_BIDIR];
    s_d.bst_en    = ~s_q.gate_drive_setup_1[`MGD_GD_BST_MASK];
    s_d.ot_auto   = s_q.gate_drive_setup_1[`MGD_GD_OT_AUTO];
    s_d.sns_en    = ~s_q.gate_drive_setup_1[`MGD_GD_SNS_MASK];
    s_d.vds_en    = ~s_q.gate_drive_setup_1[`MGD_GD_VDS_MASK];
    s_d.trip_mv   = VDS_TRIP_MV[trip_code];
    s_d.gain      = 6'h05 << s_q.gate_drive_setup_1[`MGD_GD_GAIN_HI:`MGD_GD_GAIN_LO];

    // Duty command from frequency input; samples during a division are dropped
    s_d.start = i_freq_sample && !div_busy;
    if (div_done) begin
      s_d.duty       = div_duty;
      s_d.duty_valid = 1'b1;
    end

    if (!i_nrst) begin
      s_d                    = '0;
      s_d.device_setup       = `MGD_RST_DEVICE_SETUP;
      s_d.gate_drive_setup_1 = `MGD_RST_GATE_DRIVE_SETUP_1;
      s_d.gate_drive_setup_2 = `MGD_RST_GATE_DRIVE_SETUP_2;
      s_d.ssm_on             = 1'b1;
      s_d.band_min           = 17'(`MGD_BAND_HIGH_MIN_HZ);
      s_d.band_max           = 17'(`MGD_BAND_HIGH_MAX_HZ);
      s_d.ext_khz            = 11'(`MGD_EXT_RATE_BASE_KHZ);
      s_d.bst_en             = 1'b1;
      s_d.sns_en             = 1'b1;
      s_d.vds_en             = 1'b1;
      s_d.trip_mv            = VDS_TRIP_MV[0];
      s_d.gain               = 6'h05;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  mgd_duty_divider u_div (
    .i_sys_clk       (i_sys_clk),
    .i_nrst          (i_nrst),
    .i_start         (s_q.start),
    .i_freq_hz       (i_freq_hz),
    .i_full_scale_hz (s_q.device_setup[`MGD_DS_MAX_FREQ_HI:`MGD_DS_MAX_FREQ_LO]),
    .o_busy          (div_busy),
    .o_done          (div_done),
    .o_duty_pct      (div_duty)
  );

  mgd_deadtime_map u_dt (
    .i_sys_clk         (i_sys_clk),
    .i_nrst            (i_nrst),
    .i_code            (dt_code),
    .o_deadtime_ns     (o_deadtime_ns),
    .o_deadtime_cycles (o_deadtime_cycles)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_rd_data                = s_q.rd_data;
  assign o_rd_valid               = s_q.rd_valid;
  assign o_addr_err               = s_q.addr_err;
  assign o_duty_pct               = s_q.duty;
  assign o_duty_valid             = s_q.duty_valid;
  assign o_aux_feature_enable     = s_q.aux_en;
  assign o_spread_spectrum_on     = s_q.ssm_on;
  assign o_sleep_select           = s_q.sleep_sel;
  assign o_pwm_band_min_hz        = s_q.band_min;
  assign o_pwm_band_max_hz        = s_q.band_max;
  assign o_use_external_clock     = s_q.use_ext;
  assign o_clk_src_invalid        = s_q.src_bad;
  assign o_ext_clock_khz          = s_q.ext_khz;
  assign o_csa_bidirectional      = s_q.csa_bidir;
  assign o_bootstrap_fault_enable = s_q.bst_en;
  assign o_overtemp_auto_restart  = s_q.ot_auto;
  assign o_shunt_oc_enable        = s_q.sns_en;
  assign o_drain_source_oc_enable = s_q.vds_en;
  assign o_vds_trip_mv            = s_q.trip_mv;
  assign o_sense_amp_gain         = s_q.gain;
  assign o_gate_drive_setup_2     = s_q.gate_drive_setup_2;
endmodule

/* File: include/mgd_params.svh */
// Purpose: Offsets, field positions, reset values and timing figures of the
//          gate-drive configuration bank.
// Assumes: Included by bare name from the package and design files.
// Notes:   Offsets are register indices; byte address is four times the index.
`ifndef MGD_PARAMS_SVH
`define MGD_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define MGD_OFS_DEVICE_SETUP       8'h00AA
`define MGD_OFS_GATE_DRIVE_SETUP_1 8'h00AC
`define MGD_OFS_GATE_DRIVE_SETUP_2 8'h00AE

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MGD_RST_DEVICE_SETUP       32'h0000_2000
`define MGD_RST_GATE_DRIVE_SETUP_1 32'h0000_0000
`define MGD_RST_GATE_DRIVE_SETUP_2 32'h0000_0000

// ----------------------------------------------------------------
// Device setup field positions
// ----------------------------------------------------------------
`define MGD_DS_MAX_FREQ_HI    30
`define MGD_DS_MAX_FREQ_LO    16
`define MGD_DS_AUX_EN         15
`define MGD_DS_SSM_DIS        14
`define MGD_DS_LOW_POWER      11
`define MGD_DS_PWM_BAND       10
`define MGD_DS_CLK_SRC_HI     9
`define MGD_DS_CLK_SRC_LO     8
`define MGD_DS_EXTERNAL_CLOCK_ENABLE     7
`define MGD_DS_EXT_RATE_HI    6
`define MGD_DS_EXT_RATE_LO    4
`define MGD_DS_DEADTIME_HI    3
`define MGD_DS_DEADTIME_LO    0

// ----------------------------------------------------------------
// Gate-drive setup 1 field positions
// ----------------------------------------------------------------
`define MGD_GD_CSA_BIDIR      18
`define MGD_GD_BST_MASK       16
`define MGD_GD_OT_AUTO        15
`define MGD_GD_SNS_MASK       9
`define MGD_GD_VDS_MASK       8
`define MGD_GD_TRIP_HI        6
`define MGD_GD_TRIP_LO        3
`define MGD_GD_GAIN_HI        1
`define MGD_GD_GAIN_LO        0

// ----------------------------------------------------------------
// Clock sources, rates and timing
// ----------------------------------------------------------------
`define MGD_CLK_SRC_INTERNAL  2'h0
`define MGD_CLK_SRC_EXTERNAL  2'h3
`define MGD_EXT_RATE_BASE_KHZ 8
`define MGD_BAND_HIGH_MIN_HZ  325
`define MGD_BAND_HIGH_MAX_HZ  95000
`define MGD_BAND_LOW_MIN_HZ   10
`define MGD_BAND_LOW_MAX_HZ   325
`define MGD_CLK_PERIOD_NS     5
`define MGD_DT_FINE_STEP_NS   50
`define MGD_DT_COARSE_STEP_NS 100
`define MGD_DT_FINE_LAST      4'hA
`define MGD_DT_FINE_MAX_NS    500

`endif

/* File: include/mgd_pkg.sv */
// Purpose: Types shared by the gate-drive configuration bank.
// Assumes: mgd_params.svh holds the offsets, field positions, reset values and timing constants.
// Notes:   Types only.
package mgd_pkg;
  `include "mgd_params.svh"

  typedef enum logic [1:0] {
    MGD_ST_IDLE,
    MGD_ST_DIVIDE,
    MGD_ST_DONE
  } mgd_div_state_type;

  typedef enum logic {
    MGD_LP_STANDBY,
    MGD_LP_SLEEP
  } mgd_low_power_type;
endpackage

/* File: core/mgd_deadtime_map.sv */
// Purpose: Converts the dead-time code into nanoseconds and clock cycles.
// Assumes: One clock; code is a registered field.
// Notes:   Cycle count rounds up so the inserted gap is never short.
`include "mgd_params.svh"
module mgd_deadtime_map
  import mgd_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_nrst,
  input  wire logic [3:0]  i_code,
  output logic      [10:0] o_deadtime_ns,
  output logic      [7:0]  o_deadtime_cycles
);
  typedef struct packed {
    logic [10:0] ns;
    logic [7:0]  cyc;
  } mgd_dt_state_type;

  mgd_dt_state_type state_q;
  mgd_dt_state_type state_d;
  logic [10:0]      ns_calc;

  // ----------------------------------------------------------------
  // Code to time
  // ----------------------------------------------------------------
  always_comb begin
    if (i_code <= `MGD_DT_FINE_LAST) begin
      ns_calc = 11'(32'(i_code) * `MGD_DT_FINE_STEP_NS);
    end else begin
      ns_calc = 11'(`MGD_DT_FINE_MAX_NS + 32'(i_code - `MGD_DT_FINE_LAST) * `MGD_DT_COARSE_STEP_NS);
    end
    state_d.ns  = ns_calc;
    state_d.cyc = 8'((32'(ns_calc) + `MGD_CLK_PERIOD_NS - 1) / `MGD_CLK_PERIOD_NS);
    if (!i_nrst) begin
      state_d = '0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    state_q <= state_d;
  end

  assign o_deadtime_ns     = state_q.ns;
  assign o_deadtime_cycles = state_q.cyc;
endmodule

/* File: core/mgd_duty_divider.sv */
// Purpose: Computes duty command = applied frequency / full scale * 100.
// Assumes: Start is a one-cycle pulse on the same clock.
// Notes:   Restoring divider, one quotient bit per cycle; result saturates at 100.
module mgd_duty_divider
  import mgd_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_start,
  input  wire logic [14:0] i_freq_hz,
  input  wire logic [14:0] i_full_scale_hz,
  output logic             o_busy,
  output logic             o_done,
  output logic      [6:0]  o_duty_pct
);
  localparam int QW = 22;

  typedef struct packed {
    mgd_div_state_type st;
    logic [QW-1:0]     num;
    logic [QW-1:0]     quo;
    logic [QW:0]       rem;
    logic [14:0]       den;
    logic [4:0]        cnt;
    logic              done;
    logic [6:0]        duty;
  } mgd_div_reg_type;

  mgd_div_reg_type r_q;
  mgd_div_reg_type r_d;
  logic [QW:0]     trial;

  // ----------------------------------------------------------------
  // Division sequencer
  // ----------------------------------------------------------------
  always_comb begin
    r_d      = r_q;
    r_d.done = 1'b0;
    trial    = {r_q.rem[QW-1:0], r_q.num[QW-1]};
    case (r_q.st)
      MGD_ST_IDLE: begin
        if (i_start) begin
          // Zero full scale would divide by zero; report full duty instead
          if (i_full_scale_hz == 15'h0000) begin
            r_d.duty = 7'd100;
            r_d.done = 1'b1;
          end else begin
            r_d.num = QW'(32'(i_freq_hz) * 100);
            r_d.den = i_full_scale_hz;
            r_d.rem = '0;
            r_d.quo = '0;
            r_d.cnt = 5'(QW - 1);
            r_d.st  = MGD_ST_DIVIDE;
          end
        end
      end
      MGD_ST_DIVIDE: begin
        r_d.num = {r_q.num[QW-2:0], 1'b0};
        if (trial >= (QW+1)'(r_q.den)) begin
          r_d.rem = trial - (QW+1)'(r_q.den);
          r_d.quo = {r_q.quo[QW-2:0], 1'b1};
        end else begin
          r_d.rem = trial;
          r_d.quo = {r_q.quo[QW-2:0], 1'b0};
        end
        if (r_q.cnt == 5'h00) begin
          r_d.st = MGD_ST_DONE;
        end else begin
          r_d.cnt = r_q.cnt - 5'h01;
        end
      end
      MGD_ST_DONE: begin
        r_d.duty = (r_q.quo > QW'(100)) ? 7'd100 : 7'(r_q.quo);
        r_d.done = 1'b1;
        r_d.st   = MGD_ST_IDLE;
      end
      default: begin
        r_d.st = MGD_ST_IDLE;
      end
    endcase
    if (!i_nrst) begin
      r_d    = '0;
      r_d.st = MGD_ST_IDLE;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    r_q <= r_d;
  end

  assign o_busy     = (r_q.st != MGD_ST_IDLE);
  assign o_done     = r_q.done;
  assign o_duty_pct = r_q.duty;
endmodule

/* File: verification/mgd_config_regs_asserts.sv */
// Purpose: Port-level checks of the gate-drive configuration bank.
// Assumes: Decodes settle two cycles after the write strobe.
// Notes:   Bound to every instance of the bank.
`include "mgd_params.svh"
module mgd_config_regs_asserts
  import mgd_pkg::*;
(
  input wire logic        i_sys_clk,
  input wire logic        i_nrst,
  input wire logic        i_wr_en,
  input wire logic        i_rd_en,
  input wire logic [7:0]  i_addr,
  input wire logic [31:0] i_wr_data,
  input wire logic [31:0] o_rd_data,
  input wire logic        o_rd_valid,
  input wire logic        o_addr_err,
  input wire logic        o_duty_valid,
  input wire logic        o_spread_spectrum_on,
  input wire logic        o_sleep_select,
  input wire logic        o_use_external_clock,
  input wire logic [10:0] o_ext_clock_khz,
  input wire logic        o_bootstrap_fault_enable,
  input wire logic        o_shunt_oc_enable,
  input wire logic        o_drain_source_oc_enable,
  input wire logic [5:0]  o_sense_amp_gain
);
  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  logic wr_ds;
  logic wr_gd;
  logic acc_bad;
  assign wr_ds   = i_wr_en && (i_addr == `MGD_OFS_DEVICE_SETUP);
  assign wr_gd   = i_wr_en && (i_addr == `MGD_OFS_GATE_DRIVE_SETUP_1);
  assign acc_bad = (i_addr != `MGD_OFS_DEVICE_SETUP) && (i_addr != `MGD_OFS_GATE_DRIVE_SETUP_1)
                   && (i_addr != `MGD_OFS_GATE_DRIVE_SETUP_2);

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  AST_RD_VALID: assert property (i_rd_en |=> o_rd_valid)
    else $error("read strobe gave no valid pulse");
  AST_ADDR_ERR: assert property ((i_wr_en || i_rd_en) |=> (o_addr_err == $past(acc_bad)))
    else $error("address error flag disagrees with offset");
  AST_BAD_RD_ZERO: assert property ((i_rd_en && acc_bad) |=> (o_rd_data == 32'h0000_0000))
    else $error("unlisted offset read returned data");
  AST_SSM: assert property (wr_ds |-> ##2 (o_spread_spectrum_on == !$past(i_wr_data[14], 2)))
    else $error("spread spectrum polarity wrong");
  AST_SLEEP: assert property (wr_ds |-> ##2 (o_sleep_select == $past(i_wr_data[11], 2)))
    else $error("low power select wrong");
  AST_EXT_USE: assert property (wr_ds |-> ##2
    (o_use_external_clock == (($past(i_wr_data[9:8], 2) == 2'h3) && $past(i_wr_data[7], 2))))
    else $error("external clock use wrong");
  AST_EXT_KHZ: assert property (wr_ds |-> ##2 (o_ext_clock_khz == (11'h008 << $past(i_wr_data[6:4], 2))))
    else $error("external clock rate wrong");
  AST_GAIN: assert property (wr_gd |-> ##2 (o_sense_amp_gain == (6'h05 << $past(i_wr_data[1:0], 2))))
    else $error("sense gain wrong");
  AST_FAULT_EN: assert property (wr_gd |-> ##2
    ({o_bootstrap_fault_enable, o_shunt_oc_enable, o_drain_source_oc_enable}
     == ~{$past(i_wr_data[16], 2), $past(i_wr_data[9], 2), $past(i_wr_data[8], 2)}))
    else $error("fault enables wrong");
  AST_DUTY_HOLD: assert property (o_duty_valid |=> o_duty_valid)
    else $error("duty valid dropped");

  COV_WR_DS: cover property (wr_ds);
  COV_BAD_RD: cover property (i_rd_en && acc_bad);
  COV_DUTY: cover property ($rose(o_duty_valid));
endmodule

bind mgd_config_regs mgd_config_regs_asserts chk_i (
  .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
  .i_addr(i_addr), .i_wr_data(i_wr_data), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
  .o_addr_err(o_addr_err), .o_duty_valid(o_duty_valid), .o_spread_spectrum_on(o_spread_spectrum_on),
  .o_sleep_select(o_sleep_select), .o_use_external_clock(o_use_external_clock),
  .o_ext_clock_khz(o_ext_clock_khz), .o_bootstrap_fault_enable(o_bootstrap_fault_enable),
  .o_shunt_oc_enable(o_shunt_oc_enable), .o_drain_source_oc_enable(o_drain_source_oc_enable),
  .o_sense_amp_gain(o_sense_amp_gain)
);

/* File: verification/mgd_config_regs_tb.sv */
// Purpose: Self-checking bench of the gate-drive configuration bank.
// Assumes: Decoded outputs settle within three cycles of a write.
// Notes:   Duty results are read a fixed 30 cycles after sampling.
`include "mgd_params.svh"
module mgd_config_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import mgd_pkg::*;

  logic        i_sys_clk = 1'b0;
  logic        i_nrst = 1'b0;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wr_data = 32'h0000_0000;
  logic        freq_sample = 1'b0;
  logic [14:0] freq_hz = 15'h0000;
  logic [31:0] o_rd_data;
  logic        o_rd_valid, o_addr_err, o_duty_valid, o_aux, o_ssm_on, o_sleep, o_use_ext, o_src_bad;
  logic        o_csa_bi, o_bst_en, o_ot_auto, o_sns_en, o_vds_en;
  logic [6:0]  o_duty_pct;
  logic [16:0] o_band_min, o_band_max;
  logic [10:0] o_ext_khz, o_dt_ns;
  logic [7:0]  o_dt_cyc;
  logic [11:0] o_trip;
  logic [5:0]  o_gain;
  logic [31:0] o_gds2;
  int          failures = 0;
  int          samples_checked = 0;

  mgd_config_regs uut (
    .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr),
    .i_wr_data(wr_data), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .o_addr_err(o_addr_err),
    .i_freq_sample(freq_sample), .i_freq_hz(freq_hz), .o_duty_pct(o_duty_pct), .o_duty_valid(o_duty_valid),
    .o_aux_feature_enable(o_aux), .o_spread_spectrum_on(o_ssm_on), .o_sleep_select(o_sleep),
    .o_pwm_band_min_hz(o_band_min), .o_pwm_band_max_hz(o_band_max), .o_use_external_clock(o_use_ext),
    .o_clk_src_invalid(o_src_bad), .o_ext_clock_khz(o_ext_khz), .o_deadtime_ns(o_dt_ns),
    .o_deadtime_cycles(o_dt_cyc), .o_csa_bidirectional(o_csa_bi), .o_bootstrap_fault_enable(o_bst_en),
    .o_overtemp_auto_restart(o_ot_auto), .o_shunt_oc_enable(o_sns_en), .o_drain_source_oc_enable(o_vds_en),
    .o_vds_trip_mv(o_trip), .o_sense_amp_gain(o_gain), .o_gate_drive_setup_2(o_gds2)
  );

  initial begin
    forever #2.5 i_sys_clk = ~i_sys_clk;
  end

  // ----------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Waits three edges so the dead-time path has settled too
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge i_sys_clk);
    wr_en <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
    @(posedge i_sys_clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge i_sys_clk);
    rd_en <= 1'b0;
    #1;
    chk(32'(o_rd_valid), 32'h0000_0001, "read valid");
    chk(o_rd_data, exp, "read data");
    chk(32'(o_addr_err), 32'(err), "address error");
  endtask

  task automatic duty(input logic [14:0] f, input logic [6:0] exp);
    @(posedge i_sys_clk);
    freq_hz <= f;
    freq_sample <= 1'b1;
    @(posedge i_sys_clk);
    freq_sample <= 1'b0;
    repeat (30) @(posedge i_sys_clk);
    #1;
    chk(32'(o_duty_valid), 32'h0000_0001, "duty valid");
    chk(32'(o_duty_pct), 32'(exp), "duty percent");
  endtask

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [10:0] ns;
    repeat (16) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    rd(`MGD_OFS_DEVICE_SETUP, 32'h0000_2000, 1'b0);
    rd(`MGD_OFS_GATE_DRIVE_SETUP_1, 32'h0000_0000, 1'b0);
    rd(`MGD_OFS_GATE_DRIVE_SETUP_2, 32'h0000_0000, 1'b0);
    wr(`MGD_OFS_GATE_DRIVE_SETUP_2, 32'hFFFF_FFFF);
    rd(`MGD_OFS_GATE_DRIVE_SETUP_2, 32'hFFFF_FFFF, 1'b0);
    chk(o_gds2, 32'hFFFF_FFFF, "second gate register output");
    wr(8'hAD, 32'h1234_5678);
    rd(8'hAD, 32'h0000_0000, 1'b1);
    rd(`MGD_OFS_GATE_DRIVE_SETUP_1, 32'h0000_0000, 1'b0);
    for (int c = 0; c < 16; c++) begin
      wr(`MGD_OFS_GATE_DRIVE_SETUP_1, 32'h7FF8_0000 | 32'((c << 3) | (c % 4)));
      rd(`MGD_OFS_GATE_DRIVE_SETUP_1, 32'h7FF8_0000 | 32'((c << 3) | (c % 4)), 1'b0);
      chk(32'(o_trip), (c < 8) ? 32'((c + 1) * 60) : (c == 8) ? 32'h0000_0258 : 32'(800 + (c - 9) * 200),
          "trip level");
      chk(32'(o_gain), 32'(5 << (c % 4)), "sense gain");
      ns = (c <= 10) ? 11'(c * 50) : 11'(500 + (c - 10) * 100);
      wr(`MGD_OFS_DEVICE_SETUP, 32'h0000_3000 | 32'(((c % 8) << 4) | c));
      chk(32'(o_dt_ns), 32'(ns), "dead time ns");
      chk(32'(o_dt_cyc), 32'((ns + 4) / 5), "dead time cycles");
      chk(32'(o_ext_khz), 32'(8 << (c % 8)), "external rate");
    end
    for (int b = 0; b < 2; b++) begin
      wr(`MGD_OFS_DEVICE_SETUP, 32'h0000_0300 | 32'(b * 32'h0000_CC80));
      chk({27'h0, o_aux, o_ssm_on, o_sleep, o_use_ext, o_src_bad}, 32'({b[0], ~b[0], b[0], b[0], 1'b0}),
          "device bits");
      chk(32'(o_band_min), b ? 32'h0000_000A : 32'h0000_0145, "band minimum");
      chk(32'(o_band_max), b ? 32'h0000_0145 : 32'h0001_7318, "band maximum");
      wr(`MGD_OFS_GATE_DRIVE_SETUP_1, 32'(b * 32'h0005_8300));
      chk({27'h0, o_csa_bi, o_bst_en, o_ot_auto, o_sns_en, o_vds_en},
          32'({b[0], ~b[0], b[0], ~b[0], ~b[0]}), "gate bits");
    end
    for (int s = 0; s < 4; s++) begin
      wr(`MGD_OFS_DEVICE_SETUP, 32'((s << 8) | 32'h0000_0080));
      chk({30'h0, o_use_ext, o_src_bad}, {30'h0, s == 3, s == 1 || s == 2}, "clock source");
    end
    wr(`MGD_OFS_DEVICE_SETUP, 32'h03E8_0000);
    duty(15'h01F4, 7'h32);
    duty(15'h02EE, 7'h4B);
    duty(15'h07D0, 7'h64);
    @(posedge i_sys_clk);
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    rd(`MGD_OFS_DEVICE_SETUP, 32'h0000_2000, 1'b0);
    final_report();
  end

  // Cuts a hang short
  initial begin
    #200000ns;
    failures++;
    final_report();
  end
endmodule
